// file: hdl/sync_serial_port.sv
// synchronous half-duplex serial port with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sync_serial_port
    import sync_serial_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // serial clock line
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe_n,
    // serial data line
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    // interrupt requests
    output logic tx_irq,
    output logic rx_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [DIV_WIDTH-1:0] baud_divisor;
    logic tx_interrupt_enable;
    logic rx_interrupt_enable;
    logic tx_idle_status;
    logic overrun_error;

    logic clock_source_select;
    logic transmit_enable;
    logic port_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic port_on;
    logic rx_request;
    logic rx_go;
    assign clock_source_select = tx_ctrl[TX_CLOCK_SOURCE_SELECT];
    assign transmit_enable = tx_ctrl[TX_EN];
    assign port_enable = rx_ctrl[RX_PORT_ENABLE];
    assign single_receive_enable = rx_ctrl[RX_SINGLE_RECEIVE_ENABLE];
    assign continuous_receive_enable = rx_ctrl[RX_CONTINUOUS_RECEIVE_ENABLE];
    assign port_on = tx_ctrl[TX_SYNC] && port_enable;
    // single receive means nothing to a slave
    assign rx_request = continuous_receive_enable || (single_receive_enable && clock_source_select);
    assign rx_go = port_on && rx_request && !overrun_error;

    // bus slave
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic do_write;
    logic do_read;
    logic [31:0] read_word;
    logic read_hit;
    logic write_hit;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign do_read = arvalid && arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        write_hit = (aw_addr == ADDR_TX_CTRL) || (aw_addr == ADDR_RX_CTRL) || (aw_addr == ADDR_BAUD)
            || (aw_addr == ADDR_TX_BUF) || (aw_addr == ADDR_RX_BUF) || (aw_addr == ADDR_INT_CTRL);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= write_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    logic wr_en;
    assign wr_en = do_write && w_lane;

    // receive buffer, two words deep
    logic [8:0] rx_buffer [0:1];
    logic rx_head;
    logic [1:0] rx_count;
    logic rx_push;
    logic rx_pop;
    logic [8:0] rx_word;
    assign rx_pop = do_read && (araddr == ADDR_RX_BUF) && (rx_count != 2'h0);

    always_comb begin
        read_hit = 1'b1;
        read_word = 32'h0000_0000;
        case (araddr)
            ADDR_TX_CTRL: read_word[7:0] = {tx_ctrl[7:2], tx_idle_status, tx_ctrl[0]};
            ADDR_RX_CTRL: read_word[7:0] = {rx_ctrl[7:2], overrun_error, rx_buffer[rx_head][8]};
            ADDR_BAUD: read_word[DIV_WIDTH-1:0] = baud_divisor;
            ADDR_TX_BUF: read_word = 32'h0000_0000;
            ADDR_RX_BUF: read_word[7:0] = rx_buffer[rx_head][7:0];
            ADDR_INT_CTRL: read_word[3:0] = {rx_interrupt_enable, tx_interrupt_enable, rx_irq_flag(rx_count),
                tx_buffer_empty_flag_c()};
            default: read_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (do_read) begin
            rvalid <= 1'b1;
            rdata <= read_word;
            rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // transmit buffer
    logic [8:0] tx_buffer;
    logic tx_buffer_full;
    logic tx_buffer_empty_flag;
    logic [8:0] tx_shift_register;
    logic tsr_full;
    logic tx_move;
    logic tx_done;
    assign tx_buffer_empty_flag = transmit_enable && !tx_buffer_full;
    assign tx_move = transmit_enable && tx_buffer_full && !tsr_full;

    function automatic logic rx_irq_flag(input logic [1:0] cnt);
        return cnt != 2'h0;
    endfunction
    function automatic logic tx_buffer_empty_flag_c();
        return tx_buffer_empty_flag;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_ctrl <= TX_CTRL_RESET;
            baud_divisor <= BAUD_RESET[DIV_WIDTH-1:0];
            {rx_interrupt_enable, tx_interrupt_enable} <= INT_RESET;
        end else if (wr_en) begin
            if (aw_addr == ADDR_TX_CTRL) begin
                tx_ctrl <= w_byte & TX_CTRL_WMASK;
            end
            if (aw_addr == ADDR_BAUD) begin
                baud_divisor <= w_byte[DIV_WIDTH-1:0];
            end
            if (aw_addr == ADDR_INT_CTRL) begin
                rx_interrupt_enable <= w_byte[INT_RX_INTERRUPT_ENABLE];
                tx_interrupt_enable <= w_byte[INT_TX_INTERRUPT_ENABLE];
            end
        end
    end

    // a load while the buffer is still full is dropped so no queued word is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer <= 9'h000;
            tx_buffer_full <= 1'b0;
        end else if (tx_move) begin
            tx_buffer_full <= 1'b0;
        end else if (wr_en && aw_addr == ADDR_TX_BUF && !tx_buffer_full) begin
            tx_buffer <= {tx_ctrl[TX_NINTH], w_byte};
            tx_buffer_full <= 1'b1;
        end
    end

    // link state and serial clock
    link_state_t state;
    link_state_t next_state;
    logic clock_run;
    logic tick;
    logic master_clock;
    logic rise_ev;
    logic fall_ev;
    logic [1:0] pin_level;
    logic ext_clock_prev;
    logic [3:0] word_bits;
    logic [3:0] tx_count;
    logic [3:0] rx_count_bits;
    logic [8:0] rx_shift;
    logic [8:0] next_rx_shift;
    logic serial_bit;

    assign clock_run = port_on && clock_source_select && (state != LINK_IDLE);

    baud_tick #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(clock_run),
        .divisor(baud_divisor),
        .tick(tick)
    );

    pin_sync #(
        .WIDTH(2)
    ) u_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({serial_data_line_in, serial_clock_line_in}),
        .level(pin_level)
    );

    // master clock idles low, so each word starts with a rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn || !clock_run) begin
            master_clock <= 1'b0;
        end else if (tick) begin
            master_clock <= !master_clock;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_clock_prev <= 1'b0;
        end else begin
            ext_clock_prev <= pin_level[0];
        end
    end

    always_comb begin
        if (clock_source_select) begin
            rise_ev = clock_run && tick && !master_clock;
            fall_ev = clock_run && tick && master_clock;
        end else begin
            rise_ev = port_on && pin_level[0] && !ext_clock_prev;
            fall_ev = port_on && !pin_level[0] && ext_clock_prev;
        end
    end

    assign word_bits = tx_ctrl[TX_NINE] ? BITS_NINE : BITS_EIGHT;
    assign tx_done = (state == LINK_TX) && fall_ev && (tx_count == word_bits - 4'h1);

    // receive wins the link; a paused transmit keeps its place
    always_comb begin
        next_state = state;
        case (state)
            LINK_IDLE: begin
                if (rx_go) begin
                    next_state = LINK_RX;
                end else if (tsr_full && transmit_enable && port_on) begin
                    next_state = LINK_TX;
                end
            end
            LINK_TX: begin
                if (!transmit_enable || !port_on || tx_done) begin
                    next_state = LINK_IDLE;
                end else if (rx_go) begin
                    next_state = LINK_RX;
                end
            end
            LINK_RX: begin
                if (!rx_go) begin
                    next_state = LINK_IDLE;
                end
            end
            default: next_state = LINK_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // transmit shifter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_register <= 9'h000;
            tsr_full <= 1'b0;
            tx_count <= 4'h0;
            tx_idle_status <= 1'b1;
            serial_bit <= 1'b1;
        end else if (!transmit_enable) begin
            tsr_full <= 1'b0;
            tx_count <= 4'h0;
            tx_idle_status <= 1'b1;
        end else if (tx_move) begin
            tx_shift_register <= tx_buffer;
            tsr_full <= 1'b1;
            tx_count <= 4'h0;
            tx_idle_status <= 1'b0;
        end else if (state == LINK_TX) begin
            if (rise_ev) begin
                serial_bit <= tx_shift_register[0];
                tx_shift_register <= {1'b0, tx_shift_register[8:1]};
            end
            if (fall_ev) begin
                tx_count <= tx_count + 4'h1;
            end
            if (tx_done) begin
                tsr_full <= 1'b0;
                tx_idle_status <= 1'b1;
            end
        end
    end

    // receive shifter, sampling on falling edges
    assign next_rx_shift = {pin_level[1], rx_shift[8:1]};
    assign rx_push = (state == LINK_RX) && rx_go && fall_ev
        && (rx_count_bits == (rx_ctrl[RX_NINE] ? BITS_NINE : BITS_EIGHT) - 4'h1);
    assign rx_word = rx_ctrl[RX_NINE] ? next_rx_shift : {1'b0, next_rx_shift[8:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn || state != LINK_RX) begin
            rx_shift <= 9'h000;
            rx_count_bits <= 4'h0;
        end else if (rx_push) begin
            rx_count_bits <= 4'h0;
        end else if (fall_ev) begin
            rx_shift <= next_rx_shift;
            rx_count_bits <= rx_count_bits + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_head <= 1'b0;
            rx_count <= 2'h0;
            rx_buffer[0] <= 9'h000;
            rx_buffer[1] <= 9'h000;
        end else begin
            if (rx_push && rx_count != RX_DEPTH) begin
                rx_buffer[rx_head ^ rx_count[0]] <= rx_word;
            end
            if (rx_pop) begin
                rx_head <= !rx_head;
            end
            if (rx_push && rx_count != RX_DEPTH && !rx_pop) begin
                rx_count <= rx_count + 2'h1;
            end else if (rx_pop && !(rx_push && rx_count != RX_DEPTH)) begin
                rx_count <= rx_count - 2'h1;
            end
        end
    end

    // software writes first, hardware clear of single receive and overrun set after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ctrl <= RX_CTRL_RESET;
            overrun_error <= 1'b0;
        end else begin
            if (wr_en && aw_addr == ADDR_RX_CTRL) begin
                rx_ctrl <= w_byte & RX_CTRL_WMASK;
            end
            if (!continuous_receive_enable) begin
                overrun_error <= 1'b0;
            end
            if (rx_push && !continuous_receive_enable) begin
                rx_ctrl[RX_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            end
            if (rx_push && rx_count == RX_DEPTH) begin
                overrun_error <= 1'b1;
            end
        end
    end

    // pins: data floats whenever receive is requested, clock drives only as master
    assign serial_data_line_oe_n = !(port_on && transmit_enable && !rx_request);
    assign serial_clock_line_oe_n = !(port_on && clock_source_select
        && (transmit_enable || rx_request));
    assign serial_data_line_out = serial_bit;
    assign serial_clock_line_out = master_clock;

    assign tx_irq = tx_buffer_empty_flag && tx_interrupt_enable;
    assign rx_irq = (rx_count != 2'h0) && rx_interrupt_enable;

    a_half_duplex: assert property ((state == LINK_RX) && rx_go |-> serial_data_line_oe_n)
        else $error("data driven during receive");
    a_sync_off: assert property (!tx_ctrl[TX_SYNC] |-> serial_data_line_oe_n && serial_clock_line_oe_n)
        else $error("pins driven outside sync mode");
    a_port_off: assert property (!port_enable |-> ##1 state == LINK_IDLE)
        else $error("link busy with port disabled");
    a_master_clock: assert property (port_on && clock_source_select && rx_request
        |-> !serial_clock_line_oe_n)
        else $error("master clock not driven");
    a_data_edge: assert property ($changed(serial_data_line_out) |-> $past(rise_ev))
        else $error("data changed off rising edge");
    a_tx_abort: assert property ($fell(transmit_enable) |-> ##1 !tsr_full && tx_idle_status
        && serial_data_line_oe_n)
        else $error("transmit not reset on disable");
    a_rx_abort: assert property ($rose(rx_request) && port_on && state == LINK_TX
        |-> ##1 state == LINK_RX)
        else $error("transmit not aborted by receive");
    a_single_done: assert property (rx_push && !continuous_receive_enable
        && !(wr_en && aw_addr == ADDR_RX_CTRL) |-> ##1 !single_receive_enable)
        else $error("single receive not cleared");
    a_rx_complete: assert property (rx_push && rx_count == 2'h0 && !rx_pop |-> ##1 rx_count == 2'h1)
        else $error("word not stored");
    a_overrun: assert property (rx_push && rx_count == RX_DEPTH && !rx_pop |-> ##1 overrun_error
        && rx_count == RX_DEPTH)
        else $error("overrun not flagged");
    a_idle_clear: assert property (tx_move |-> ##1 !tx_idle_status ##1 !tx_buffer_full || tx_move)
        else $error("idle not cleared on move");
endmodule // sync_serial_port

// file: include/sync_serial_pkg.sv
// constants, register map and types of the synchronous serial port
// Functional notes
// - Transmit and receive never run together; one blocks the other.
// - Sync select, transmit control bit 4, puts the port in synchronous mode.
// - Port enable, receive control bit 7, gives both pins to the serial link.
// - Clock source select, transmit control bit 7, makes us master driving the clock.
// - A data bit leaves on a rising clock edge and holds across the falling edge.
// - Clearing transmit enable aborts and resets the transmitter; data floats, and the clock floats unless a master receive is requested.
// - Receive enable during transmit aborts it; data floats, master clock stays driven.
// - After a single word interrupts transmit, single receive clears and transmit resumes.
// - Master receive runs on single or continuous enable, sampling on falling edges.
// - Single receive takes one word; continuous runs until cleared and wins.
// - Each received word raises receive complete and, if enabled, an interrupt.
// - With clock source clear we are slave, shifting on the external clock.
// - In slave transmit a second word waits buffered; buffer empty stays low.
// - Buffer empty is set while transmit enabled and buffer empty; only a load or clearing transmit enable clears it.
// - Transmit idle clears on a move to the shifter and sets at word end.
// - Receive buffer holds two words; a third sets overrun and blocks until toggled.
package sync_serial_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_BAUD = 8'h08;
    localparam logic [7:0] ADDR_TX_BUF = 8'h0C;
    localparam logic [7:0] ADDR_RX_BUF = 8'h10;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h14;

    localparam int TX_CLOCK_SOURCE_SELECT = 7;
    localparam int TX_NINE = 6;
    localparam int TX_EN = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_IDLE = 1;
    localparam int TX_NINTH = 0;
    localparam int RX_PORT_ENABLE = 7;
    localparam int RX_NINE = 6;
    localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RX_OVERRUN_ERROR = 1;
    localparam int RX_NINTH = 0;
    localparam int INT_TX_BUFFER_EMPTY_FLAG = 0;
    localparam int INT_RX_COMPLETE_FLAG = 1;
    localparam int INT_TX_INTERRUPT_ENABLE = 2;
    localparam int INT_RX_INTERRUPT_ENABLE = 3;

    localparam logic [7:0] TX_CTRL_WMASK = 8'hF1;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hF0;
    localparam logic [7:0] TX_CTRL_RESET = 8'h00;
    localparam logic [7:0] RX_CTRL_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [1:0] INT_RESET = 2'h0;

    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [1:0] RX_DEPTH = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_TX = 2'b01,
        LINK_RX = 2'b10
    } link_state_t;

endpackage

// file: hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins and filtered levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // stage1 feeds stage2 only; a change counts once stage2 and stage3 agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level);
        end
    end
endmodule // pin_sync

// file: hdl/baud_tick.sv
// half-period tick generator for the master serial clock
`timescale 1ns/1ps
module baud_tick #(
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [DIV_WIDTH-1:0] divisor,
    // one pulse every divisor+1 cycles while running
    output logic tick
);
    logic [DIV_WIDTH-1:0] count;

    assign tick = run && (count == divisor);

    // restarting from zero keeps the first half period full length
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || tick) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule // baud_tick

// file: test/far_end.sv
// far-end partner: captures device bits and feeds bits back
`timescale 1ns/1ps
module far_end (
    // resolved link lines and the word to feed back
    input wire logic ck,
    input wire logic dt,
    input wire logic [7:0] tx_word,
    // partner drive and capture
    output logic ck_drv,
    output logic dt_drv,
    output logic [7:0] rx_word
);
    int n = 0;
    initial begin
        ck_drv = 0;
        dt_drv = 1;
        rx_word = 0;
    end
    // lsb first, bit held across the fall
    always @(negedge ck) rx_word <= {dt, rx_word[7:1]};
    // change after a rise so the falling-edge sample sees a settled bit
    always @(posedge ck) begin
        dt_drv <= tx_word[n];
        n <= (n + 1) % 8;
    end
    // slave frames; clock stands still low between them
    task automatic frame(input int bits);
        repeat (bits) begin
            #62.5 ck_drv = 1;
            #62.5 ck_drv = 0;
        end
    endtask
endmodule // far_end

// file: test/sync_serial_master_slave_tb.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module sync_serial_master_slave_tb import sync_serial_pkg::*;;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ck_out, ck_oe_n, dt_out, dt_oe_n, tx_irq, rx_irq;
    logic ck, dt, p_ck, p_dt;
    logic [7:0] awaddr = 0, araddr = 0, p_tx = 0, p_rx, b, w2;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [33:0] q[$];
    int seed = 15, miscompares = 0, num_checks = 0;
    always #5 aclk = ~aclk;
    // clock and data lines take the far-end partner's drive when the device floats them
    assign ck = !ck_oe_n ? ck_out : p_ck;
    assign dt = !dt_oe_n ? dt_out : p_dt;
    sync_serial_port dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .serial_clock_line_in(ck),
        .serial_clock_line_out(ck_out), .serial_clock_line_oe_n(ck_oe_n), .serial_data_line_in(dt),
        .serial_data_line_out(dt_out), .serial_data_line_oe_n(dt_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
    far_end p (.ck(ck), .dt(dt), .tx_word(p_tx), .ck_drv(p_ck), .dt_drv(p_dt), .rx_word(p_rx));
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        chk(34'(bresp), 34'(RESP_OKAY));
    endtask
    // expectation noted first; the monitor pops it when the answer shows
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        q.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
    endtask
    always @(posedge aclk) if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata}, q.pop_front());
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(ADDR_TX_CTRL, 34'h2);
        rd(ADDR_INT_CTRL, 34'h0);
        rd(8'h18, {RESP_SLVERR, 32'h0});
        $display("test reset_map done");
        b = 8'($random(seed));
        wr(ADDR_BAUD, 32'h7);
        wr(ADDR_RX_CTRL, 32'h80);
        wr(ADDR_TX_CTRL, 32'hB0);
        rd(ADDR_INT_CTRL, 34'h1);
        wr(ADDR_TX_BUF, 32'(b));
        repeat (200) @(posedge aclk);
        chk(34'(p_rx), 34'(b));
        rd(ADDR_TX_CTRL, 34'hB2);
        $display("test master_tx done");
        wr(ADDR_TX_BUF, 32'(b ^ 8'hFF));
        repeat (30) @(posedge aclk);
        chk(34'(ck_oe_n), 34'h0);
        wr(ADDR_TX_CTRL, 32'h90);
        chk(34'({ck_oe_n, dt_oe_n}), 34'h3);
        rd(ADDR_TX_CTRL, 34'h92);
        $display("test abort done");
        p_tx <= 8'($random(seed));
        p.n = 0;
        wr(ADDR_INT_CTRL, 32'hC);
        wr(ADDR_RX_CTRL, 32'hA0);
        repeat (200) @(posedge aclk);
        chk(34'({dt_oe_n, rx_irq}), 34'h3);
        rd(ADDR_INT_CTRL, 34'hE);
        rd(ADDR_RX_CTRL, 34'h80);
        rd(ADDR_RX_BUF, 34'(p_tx));
        $display("test master_rx done");
        p.n = 0;
        wr(ADDR_RX_CTRL, 32'h90);
        repeat (450) @(posedge aclk);
        rd(ADDR_RX_CTRL, 34'h92);
        rd(ADDR_RX_BUF, 34'(p_tx));
        rd(ADDR_RX_BUF, 34'(p_tx));
        wr(ADDR_RX_CTRL, 32'h80);
        rd(ADDR_RX_CTRL, 34'h80);
        $display("test overrun done");
        wr(ADDR_TX_CTRL, 32'hB0);
        wr(ADDR_TX_BUF, 32'(b));
        repeat (40) @(posedge aclk);
        wr(ADDR_RX_CTRL, 32'hA0);
        chk(34'({ck_oe_n, dt_oe_n}), 34'h1);
        repeat (200) @(posedge aclk);
        chk(34'(dt_oe_n), 34'h0);
        rd(ADDR_RX_CTRL, 34'h80);
        wr(ADDR_TX_CTRL, 32'h90);
        $display("test rx_interrupt done");
        w2 = 8'($random(seed));
        wr(ADDR_TX_CTRL, 32'h71);
        wr(ADDR_TX_BUF, 32'(b));
        wr(ADDR_TX_BUF, 32'(w2));
        chk(34'(tx_irq), 34'h0);
        rd(ADDR_INT_CTRL, 34'hE);
        p.frame(9);
        repeat (8) @(posedge aclk);
        chk(34'({tx_irq, p_rx}), 34'({2'h3, b[7:1]}));
        rd(ADDR_INT_CTRL, 34'hF);
        p.frame(9);
        repeat (8) @(posedge aclk);
        chk(34'(p_rx), 34'({1'b1, w2[7:1]}));
        rd(ADDR_TX_CTRL, 34'h73);
        $display("test slave_tx done");
        end_sim;
    end
endmodule // sync_serial_master_slave_tb
